// [hbc_top.sv]
// h-bridge control and fault logic with a wishbone register port
// assumes control pins and fault detectors arrive unsynchronised
//
// Contract
// [RL1] drive only when awake, both disables released, no fault; equal inputs also drive
// [RL2] both inputs high turn on both high sides; both low both low sides
// [RL3] each half-bridge follows its own polarity input independently
// [RL4] either disable asserted switches all four switches off
// [RL5] sleep control low puts the bridge into sleep with outputs off
// [RL6] undervoltage, short or overtemperature tri-states outputs and pulls flag low
// [RL7] host toggles a disable input or cycles supply to clear the flag
// [RL8] undervoltage shutdown recovers by itself when the condition ends
// [RL9] a short latches outputs off whatever the inputs and pulls flag low
// [RL10] disable falling or inverted disable rising releases the short latch
// [RL11] with no latch and normal temperature outputs follow the inputs
// [RL12] current at the limit tri-states outputs for a fixed off-time
// [RL13] limit ramps down above 160 C to floor at 175 C; beyond, shutdown
// [RL14] overtemperature latches outputs off and pulls the flag low
// [RL15] overtemperature clears only when temperature is below threshold minus hysteresis
// [RL16] a successful latch release returns the fault flag high
// [RL17] host keeps input switching at or below 10 kHz
// [RL18] first input sets first output, second input sets second output
// [RL19] after undervoltage the present inputs are resumed and the flag rises
// [RL20] sleep keeps both outputs high impedance whatever other inputs are
// [RL21] all control inputs synchronised; clear edges seen on synced disables
// [RL22] off period timed by a clock-cycle counter at the typical off-time
`timescale 1ns/100ps
module hbc_top #(
  parameter int unsigned OFF_CYCLES = hbc_pkg::OFF_TIME_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        enable_awake,
  input  wire logic        polarity_input_a,
  input  wire logic        polarity_input_b,
  input  wire logic        disable_active_high,
  input  wire logic        disable_active_low,
  input  wire logic        undervoltage_detect,
  input  wire logic        short_circuit_detect,
  input  wire logic [11:0] current_sense_feedback,
  input  wire logic [7:0]  junction_temp,
  output logic             bridge_out_a,
  output logic             bridge_out_a_oe_n,
  output logic             bridge_out_b,
  output logic             bridge_out_b_oe_n,
  output logic             high_side_a_on,
  output logic             low_side_a_on,
  output logic             high_side_b_on,
  output logic             low_side_b_on,
  output logic             fault_flag_n,
  output logic             fault_flag_oe_n
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [4:0] ctl_s;
  logic [1:0] det_s;
  logic       en_s, in_a_s, in_b_s, dis_h_s, dis_l_s;
  logic       uv_s, short_s;

  // control pins; reset values put the bridge asleep and disabled
  hbc_sync #(.WIDTH(5)) u_sync_ctl ( // RL21
    .clk      (clk),
    .reset_n  (reset_n),
    .rst_val  (5'h08),
    .async_in ({disable_active_low, disable_active_high, polarity_input_b,
                polarity_input_a, enable_awake}),
    .sync_out (ctl_s)
  );

  // analog fault detectors
  hbc_sync #(.WIDTH(2)) u_sync_det ( // RL21
    .clk      (clk),
    .reset_n  (reset_n),
    .rst_val  (2'h0),
    .async_in ({short_circuit_detect, undervoltage_detect}),
    .sync_out (det_s)
  );

  assign en_s    = ctl_s[0];
  assign in_a_s  = ctl_s[1];
  assign in_b_s  = ctl_s[2];
  assign dis_h_s = ctl_s[3];
  assign dis_l_s = ctl_s[4];
  assign uv_s    = det_s[0];
  assign short_s = det_s[1];

  // ----------------------------------------------------------------
  // sense words and disable edge detection
  // ----------------------------------------------------------------
  logic [11:0] cur_q;
  logic [7:0]  temp_q;
  logic        dis_h_prev_q, dis_l_prev_q;
  logic        clear_edge;

  // sense samples and previous disable levels
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cur_q        <= 12'h000;
      temp_q       <= 8'h00;
      dis_h_prev_q <= 1'b1;
      dis_l_prev_q <= 1'b0;
    end else begin
      cur_q        <= current_sense_feedback;
      temp_q       <= junction_temp;
      dis_h_prev_q <= dis_h_s;
      dis_l_prev_q <= dis_l_s;
    end
  end

  // falling active-high disable or rising active-low disable
  assign clear_edge = (dis_h_prev_q && !dis_h_s) || (!dis_l_prev_q && dis_l_s); // RL21

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [11:0] ilim_base_q, ilim_floor_q, limit_q;
  logic [7:0]  temp_hyst_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        wr_now;
  logic [31:0] status_w;
  logic        short_q, ot_q, off_busy, fault_flag_n_q;
  logic        hs_a_q, ls_a_q, hs_b_q, ls_b_q;

  assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  // writes land on the edge where the master samples ack
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ilim_base_q  <= hbc_pkg::ILIM_BASE_RST;
      ilim_floor_q <= hbc_pkg::ILIM_FLOOR_RST;
      temp_hyst_q  <= hbc_pkg::TEMP_HYST_RST;
    end else if (wr_now) begin
      if (wb_adr_i == hbc_pkg::REG_ILIM_BASE) begin
        if (wb_sel_i[0]) ilim_base_q[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) ilim_base_q[11:8] <= wb_dat_i[11:8];
      end
      if (wb_adr_i == hbc_pkg::REG_ILIM_FLOOR) begin
        if (wb_sel_i[0]) ilim_floor_q[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) ilim_floor_q[11:8] <= wb_dat_i[11:8];
      end
      if (wb_adr_i == hbc_pkg::REG_TEMP_HYST && wb_sel_i[0]) begin
        temp_hyst_q <= wb_dat_i[7:0];
      end
    end
  end

  assign status_w = {25'h0, !en_s, fault_flag_n_q, hs_a_q | ls_a_q,
                     off_busy, uv_s, ot_q, short_q};

  // ack one cycle after the request, dropped in the following cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      unique case (wb_adr_i)
        hbc_pkg::REG_STATUS:     rdat_q <= status_w;
        hbc_pkg::REG_ILIM_BASE:  rdat_q <= {20'h0, ilim_base_q};
        hbc_pkg::REG_ILIM_FLOOR: rdat_q <= {20'h0, ilim_floor_q};
        hbc_pkg::REG_TEMP_HYST:  rdat_q <= {24'h0, temp_hyst_q};
        hbc_pkg::REG_LIMIT_NOW:  rdat_q <= {20'h0, limit_q};
        default:                 rdat_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // temperature-dependent current limit
  // ----------------------------------------------------------------
  logic [11:0] span_cur;
  logic [3:0]  over_deg;
  logic [15:0] derate_prod;

  // linear ramp from base at 160 C down to floor at 175 C
  always_comb begin
    span_cur = (ilim_base_q > ilim_floor_q) ? ilim_base_q - ilim_floor_q : 12'h000;
    if (temp_q <= hbc_pkg::TEMP_DERATE_START) begin
      over_deg = 4'h0;
    end else if (temp_q >= hbc_pkg::TEMP_SHUTDOWN) begin
      over_deg = hbc_pkg::DERATE_SPAN;
    end else begin
      over_deg = 4'(temp_q - hbc_pkg::TEMP_DERATE_START);
    end
    derate_prod = 16'(span_cur) * 16'(over_deg);
  end

  // limit in force for the next trip decision
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      limit_q <= hbc_pkg::ILIM_BASE_RST;
    end else begin
      limit_q <= ilim_base_q - 12'(derate_prod / 16'(hbc_pkg::DERATE_SPAN)); // RL13
    end
  end

  // ----------------------------------------------------------------
  // fault latches
  // ----------------------------------------------------------------
  logic [7:0] release_temp;
  logic       ot_now, short_d, ot_d;

  assign release_temp = (temp_hyst_q < hbc_pkg::TEMP_SHUTDOWN) ?
                        hbc_pkg::TEMP_SHUTDOWN - temp_hyst_q : 8'h00;
  assign ot_now = temp_q > hbc_pkg::TEMP_SHUTDOWN; // RL13

  // set wins over a clear edge in the same cycle
  always_comb begin
    short_d = short_q;
    if (clear_edge) short_d = 1'b0; // RL10
    if (short_s) short_d = 1'b1; // RL9
    ot_d = ot_q;
    if (clear_edge && temp_q < release_temp) ot_d = 1'b0; // RL15
    if (ot_now) ot_d = 1'b1; // RL14
  end

  // latched faults and the active-low flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      short_q        <= 1'b0;
      ot_q           <= 1'b0;
      fault_flag_n_q <= 1'b1;
    end else begin
      short_q <= short_d;
      ot_q    <= ot_d;
      // flag follows live undervoltage, disable while awake, latched faults
      fault_flag_n_q <= !(short_d || ot_d || uv_s || // RL6 RL16 RL19
                          (en_s && (dis_h_s || !dis_l_s)));
    end
  end

  assign fault_flag_n    = fault_flag_n_q;
  assign fault_flag_oe_n = fault_flag_n_q; // pull low only while flag is low

  // ----------------------------------------------------------------
  // current regulation and bridge drive
  // ----------------------------------------------------------------
  logic core_ok, drive_ok, trip;

  // awake, both disables released, no latch, supply good
  assign core_ok  = en_s && !dis_h_s && dis_l_s && !short_q && !ot_q && !uv_s; // RL1 RL4 RL5 RL8
  assign drive_ok = core_ok && !off_busy; // RL12
  assign trip     = drive_ok && (cur_q >= limit_q);

  hbc_offtimer #(.CYCLES(OFF_CYCLES)) u_offtimer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (trip), // RL12
    .busy    (off_busy)
  );

  // each half-bridge from its own input; equal inputs brake
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hs_a_q <= 1'b0;
      ls_a_q <= 1'b0;
      hs_b_q <= 1'b0;
      ls_b_q <= 1'b0;
    end else begin
      hs_a_q <= drive_ok && in_a_s; // RL2 RL3 RL11 RL18
      ls_a_q <= drive_ok && !in_a_s; // RL2 RL3
      hs_b_q <= drive_ok && in_b_s; // RL2 RL3 RL18
      ls_b_q <= drive_ok && !in_b_s; // RL2 RL3
    end
  end

  assign high_side_a_on    = hs_a_q;
  assign low_side_a_on     = ls_a_q;
  assign high_side_b_on    = hs_b_q;
  assign low_side_b_on     = ls_b_q;
  assign bridge_out_a      = hs_a_q;
  assign bridge_out_b      = hs_b_q;
  assign bridge_out_a_oe_n = !(hs_a_q || ls_a_q); // RL4 RL20
  assign bridge_out_b_oe_n = !(hs_b_q || ls_b_q); // RL4 RL20

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_trip;
    trip;
  endsequence

  sequence s_off_window;
    off_busy && bridge_out_a_oe_n && bridge_out_b_oe_n;
  endsequence

  sequence s_release;
    short_q && !short_s && clear_edge;
  endsequence

  run_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // RL1
    !drive_ok |=> !hs_a_q && !ls_a_q && !hs_b_q && !ls_b_q)
    else $error("bridge driven while not permitted");

  brake_high_a: assert property (@(posedge clk) disable iff (!reset_n) // RL2
    drive_ok && in_a_s && in_b_s |=> hs_a_q && hs_b_q && !ls_a_q && !ls_b_q)
    else $error("high-side brake not applied");

  half_follow_a: assert property (@(posedge clk) disable iff (!reset_n) // RL18
    drive_ok |=> bridge_out_a == $past(in_a_s) && bridge_out_b == $past(in_b_s)
                 && !bridge_out_a_oe_n)
    else $error("output does not follow its own input");

  disable_off_a: assert property (@(posedge clk) disable iff (!reset_n) // RL4
    (dis_h_s || !dis_l_s) |=> bridge_out_a_oe_n && bridge_out_b_oe_n
                              && (!fault_flag_n || !$past(en_s)))
    else $error("disable did not tri-state outputs");

  sleep_off_a: assert property (@(posedge clk) disable iff (!reset_n) // RL20
    !en_s |=> bridge_out_a_oe_n && bridge_out_b_oe_n)
    else $error("outputs active in sleep");

  uv_flag_a: assert property (@(posedge clk) disable iff (!reset_n) // RL6
    uv_s |=> !fault_flag_n && bridge_out_a_oe_n && bridge_out_b_oe_n)
    else $error("undervoltage not reported");

  short_latch_a: assert property (@(posedge clk) disable iff (!reset_n) // RL9
    short_s |=> short_q && !fault_flag_n ##1 bridge_out_a_oe_n && bridge_out_b_oe_n)
    else $error("short circuit not latched off");

  short_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // RL10
    s_release |=> !short_q)
    else $error("disable edge did not release short latch");

  ot_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RL15
    ot_q && temp_q >= release_temp |=> ot_q)
    else $error("overtemperature released while still hot");

  ot_latch_a: assert property (@(posedge clk) disable iff (!reset_n) // RL14
    ot_now |=> ot_q && !fault_flag_n)
    else $error("overtemperature not latched");

  off_time_a: assert property (@(posedge clk) disable iff (!reset_n) // RL12
    s_trip |=> ##1 s_off_window [*8])
    else $error("current trip did not tri-state for the off-time");

  limit_flat_a: assert property (@(posedge clk) disable iff (!reset_n) // RL13
    temp_q <= hbc_pkg::TEMP_DERATE_START && $stable(temp_q) && $stable(ilim_base_q)
    |=> limit_q == $past(ilim_base_q))
    else $error("limit derated below the ramp start");

  uv_recover_a: assert property (@(posedge clk) disable iff (!reset_n) // RL8
    !uv_s && !short_d && !ot_d && en_s && !dis_h_s && dis_l_s |=> fault_flag_n)
    else $error("flag not restored after undervoltage");

endmodule : hbc_top

// [hbc_pkg.sv]
// constants shared by the h-bridge control and fault logic
// assumes one 250 MHz clock and a classic wishbone register port
package hbc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned OFF_TIME_NS     = 20000;
  localparam int unsigned OFF_TIME_CYCLES = OFF_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // widths and thresholds
  // ----------------------------------------------------------------
  localparam int unsigned CUR_W  = 12;
  localparam int unsigned TEMP_W = 8;
  localparam logic [7:0]  TEMP_DERATE_START = 8'hA0;
  localparam logic [7:0]  TEMP_SHUTDOWN     = 8'hAF;
  localparam logic [3:0]  DERATE_SPAN       = 4'hF;

  // ----------------------------------------------------------------
  // register reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] ILIM_BASE_RST  = 12'h28A;
  localparam logic [11:0] ILIM_FLOOR_RST = 12'h190;
  localparam logic [7:0]  TEMP_HYST_RST  = 8'h0A;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS     = 8'h00;
  localparam logic [7:0] REG_ILIM_BASE  = 8'h04;
  localparam logic [7:0] REG_ILIM_FLOOR = 8'h08;
  localparam logic [7:0] REG_TEMP_HYST  = 8'h0C;
  localparam logic [7:0] REG_LIMIT_NOW  = 8'h10;

  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_SHORT   = 0;
  localparam int unsigned ST_OVTEMP  = 1;
  localparam int unsigned ST_UNDERV  = 2;
  localparam int unsigned ST_OFFTIME = 3;
  localparam int unsigned ST_DRIVING = 4;
  localparam int unsigned ST_FLAG_N  = 5;
  localparam int unsigned ST_ASLEEP  = 6;

endpackage : hbc_pkg

// [hbc_sync.sv]
// multi-bit two-flop synchroniser for independent level inputs
// assumes each bit is a slow level; no word coherence is given
`timescale 1ns/100ps
module hbc_sync #(
  parameter int unsigned WIDTH  = 1,
  parameter int unsigned STAGES = hbc_pkg::SYNC_STAGES
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] rst_val,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // shift chain, first stage read only by the next stage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage_q [STAGES];

  // chain of flops; reset value is a constant tie at the instance
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= rst_val;
      end
    end else begin
      stage_q[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign sync_out = stage_q[STAGES-1];

endmodule : hbc_sync

// [hbc_offtimer.sv]
// fixed off-time counter for constant off-time current regulation
// assumes start is a one-cycle pulse; starts while busy are ignored
`timescale 1ns/100ps
module hbc_offtimer #(
  parameter int unsigned CYCLES = hbc_pkg::OFF_TIME_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      busy
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count_q;
  logic             busy_q;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // busy for exactly CYCLES cycles after the start pulse
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q  <= 1'b0;
      count_q <= '0;
    end else if (!busy_q) begin
      busy_q  <= start; // RL22
      count_q <= '0;
    end else if (count_q == LAST) begin
      busy_q  <= 1'b0; // RL22
      count_q <= '0;
    end else begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  assign busy = busy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  off_count_range_a: assert property (@(posedge clk) disable iff (!reset_n) // RL22
    busy_q && count_q == LAST |=> !busy_q)
    else $error("off timer ran past its terminal count");

endmodule : hbc_offtimer

// [hbc_host_model.sv]
// host controller model: drives the control pins, reads the fault line
// assumes the bench calls drive just after reset; fault line has a pull-up
`timescale 1ns/100ps
module hbc_host_model (
  input  wire logic clk,
  input  wire logic fault_flag_n,
  input  wire logic fault_flag_oe_n,
  output logic      enable_awake,
  output logic      polarity_input_a,
  output logic      polarity_input_b,
  output logic      disable_active_high,
  output logic      disable_active_low,
  output logic      fault_line_n
);
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  // asleep and disabled from time zero
  initial begin
    enable_awake        = 1'b0;
    polarity_input_a    = 1'b0;
    polarity_input_b    = 1'b0;
    disable_active_high = 1'b1;
    disable_active_low  = 1'b0;
  end

  // single level steps just after an edge, never a fast pwm train
  task drive(input logic en, input logic a, input logic b, input logic dh, input logic dl);
    @(posedge clk);
    enable_awake        <= en;
    polarity_input_a    <= a;
    polarity_input_b    <= b;
    disable_active_high <= dh;
    disable_active_low  <= dl;
  endtask : drive

  // open drain: a released line reads high through the pull-up
  assign fault_line_n = fault_flag_oe_n ? 1'b1 : fault_flag_n;
endmodule : hbc_host_model

// [hbridge_control_fault_logic_bench.sv]
// self-checking bench for the h-bridge control and fault logic
// assumes hbc_pkg, hbc_top and hbc_host_model are compiled first
`timescale 1ns/100ps
module hbridge_control_fault_logic_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned OFF    = 40;
  localparam logic [8:0]  OFF_LO = 9'h006;
  localparam logic [8:0]  OFF_HI = 9'h007;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        uv = 1'b0;
  logic        sc = 1'b0;
  logic [11:0] cur = 12'h000;
  logic [7:0]  temp = 8'h19;
  logic [31:0] rdat;
  logic [31:0] r;
  logic        ack, en, pa, pb, dh, dl, fl;
  logic        oa, ob, oea, oeb, hsa, lsa, hsb, lsb, fq, fqe;
  logic [8:0]  obs;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc_n = 0;

  // clock, timeout, observed output vector
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  assign obs = {hsa, lsa, hsb, lsb, oa, ob, oea, oeb, fl};

  hbc_top #(.OFF_CYCLES(OFF)) i_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .enable_awake(en), .polarity_input_a(pa),
    .polarity_input_b(pb), .disable_active_high(dh), .disable_active_low(dl),
    .undervoltage_detect(uv), .short_circuit_detect(sc), .current_sense_feedback(cur),
    .junction_temp(temp), .bridge_out_a(oa), .bridge_out_a_oe_n(oea), .bridge_out_b(ob),
    .bridge_out_b_oe_n(oeb), .high_side_a_on(hsa), .low_side_a_on(lsa),
    .high_side_b_on(hsb), .low_side_b_on(lsb), .fault_flag_n(fq), .fault_flag_oe_n(fqe));
  hbc_host_model i_host (.clk(clk), .fault_flag_n(fq), .fault_flag_oe_n(fqe),
    .enable_awake(en), .polarity_input_a(pa), .polarity_input_b(pb),
    .disable_active_high(dh), .disable_active_low(dl), .fault_line_n(fl));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // expected outputs while driving: gates, levels, enables, flag high
  function automatic logic [8:0] fwd(input logic a, input logic b);
    return {a, !a, b, !b, a, b, 3'h1};
  endfunction : fwd

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // pins then a settle time well past the sync and gate latency
  task set(input logic e, input logic a, input logic b, input logic h, input logic l);
    i_host.drive(e, a, b, h, l);
    repeat (8) @(posedge clk);
  endtask : set

  // classic wishbone single cycle, waits for ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset", obs, OFF_HI);
    for (int i = 0; i < 4; i++) begin
      set(1'b1, i[1], i[0], 1'b0, 1'b1);
      chk("drive", obs, fwd(i[1], i[0]));
    end
    set(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    chk("dis_h", obs, OFF_LO);
    set(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("dis_l", obs, OFF_LO);
    set(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    chk("sleep", obs, OFF_HI);
    set(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("sleep_dis", obs, OFF_HI);
    // undervoltage recovers by itself
    set(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    uv <= 1'b1;
    repeat (8) @(posedge clk);
    chk("uv", obs, OFF_LO);
    wb(1'b0, hbc_pkg::REG_STATUS, 32'h0);
    chk("uv_bit", r[hbc_pkg::ST_UNDERV], 1'b1);
    uv <= 1'b0;
    repeat (8) @(posedge clk);
    chk("uv_back", obs, fwd(1'b1, 1'b0));
    // short latch, set wins over clear, then release
    sc <= 1'b1;
    set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("short", obs, OFF_LO);
    set(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("short_held", obs, OFF_LO);
    sc <= 1'b0;
    set(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    chk("short_latch", obs, OFF_LO);
    wb(1'b0, hbc_pkg::REG_STATUS, 32'h0);
    chk("short_bit", r[hbc_pkg::ST_SHORT], 1'b1);
    set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("short_clr", obs, fwd(1'b0, 1'b1));
    // overtemperature latch with hysteresis on release
    temp <= 8'hB0;
    set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("ovt", obs, OFF_LO);
    temp <= 8'hAA;
    set(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("ovt_hot", obs, OFF_LO);
    temp <= 8'h64;
    set(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("ovt_clr", obs, fwd(1'b0, 1'b1));
    // registers and derated limit
    wb(1'b0, hbc_pkg::REG_ILIM_BASE, 32'h0);
    chk("base", r, 32'h0000028A);
    wb(1'b0, hbc_pkg::REG_ILIM_FLOOR, 32'h0);
    chk("floor", r, 32'h00000190);
    wb(1'b0, hbc_pkg::REG_TEMP_HYST, 32'h0);
    chk("hyst", r, 32'h0000000A);
    temp <= 8'hA0;
    wb(1'b0, hbc_pkg::REG_LIMIT_NOW, 32'h0);
    chk("lim_160", r, 32'h0000028A);
    temp <= 8'hAF;
    repeat (4) @(posedge clk);
    wb(1'b0, hbc_pkg::REG_LIMIT_NOW, 32'h0);
    chk("lim_175", r, 32'h00000190);
    temp <= 8'h19;
    wb(1'b1, hbc_pkg::REG_ILIM_BASE, 32'h00000123);
    wb(1'b0, hbc_pkg::REG_ILIM_BASE, 32'h0);
    chk("base_wr", r, 32'h00000123);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", r, 32'h0);
    // current trip gives a fixed off time, then drive resumes
    set(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    cur <= 12'hFFF;
    repeat (2) @(posedge clk);
    cur <= 12'h000;
    repeat (6) @(posedge clk);
    chk("trip", obs, OFF_HI);
    wb(1'b0, hbc_pkg::REG_STATUS, 32'h0);
    chk("trip_bit", r[hbc_pkg::ST_OFFTIME], 1'b1);
    repeat (OFF - 12) @(posedge clk);
    chk("trip_hold", obs, OFF_HI);
    repeat (12) @(posedge clk);
    chk("trip_end", obs, fwd(1'b1, 1'b0));
    end_sim();
  end
endmodule : hbridge_control_fault_logic_bench
